// [inc/scr_pkg.sv]
// Notes on behaviour
// - Writes to either config register are taken only in DIAGNOSTIC with the lock bit at 0b.
// - Timeout select bits 5-4 give 640 ms for 00b, 320 ms for 01b, 5 ms for 10b, 1.25 ms for 11b.
// - Lock threshold bits 3-0 are the limit the four-bit error counter is compared against.
// - With the exit disable bit at 0b, SAFE goes to RESET when the SAFE timer expires.
// - With exit disable at 1b and counter at or below threshold, expiry still leads to RESET.
// - With exit disable at 1b and counter above threshold, the device stays locked in SAFE.
// - Clock warning response enable at bit 7 sends DIAGNOSTIC or ACTIVE to SAFE on a warning.
// - The analog self-test scheduler runs in ACTIVE only with bit 5 set and a group start bit set.
// - Bit 4 governs automatic self-tests during reset extension on entering RESET.
// - Automatic self-tests run when that bit is 0b and are skipped when it is 1b.
// - With the self-test failure response bit set, an analog self-test failure requests SAFE.
// - With the enable-driver error response bit set, a pin driver error requests SAFE.
// - A reset-output driver error requests RESET if enabled, else SAFE if enabled; RESET wins.
package scr_pkg;

   // Device operating state codes seen on the state input
   localparam logic [2:0] DST_OFF    = 3'h0;
   localparam logic [2:0] DST_RESET  = 3'h2;
   localparam logic [2:0] DST_DIAG   = 3'h3;
   localparam logic [2:0] DST_ACTIVE = 3'h4;
   localparam logic [2:0] DST_SAFE   = 3'h5;

   // Register select on the command port
   localparam logic CMD_SEL_ONE = 1'b0;
   localparam logic CMD_SEL_TWO = 1'b1;

   // Field positions, first register
   localparam int CFG1_TO_MSB = 5;
   localparam int CFG1_TO_LSB = 4;
   localparam int CFG1_TH_MSB = 3;
   localparam int CFG1_TH_LSB = 0;
   // Field positions, second register
   localparam int CFG2_CLKW_BIT  = 7;
   localparam int CFG2_SCHED_BIT = 5;
   localparam int CFG2_AUTO_BIT  = 4;
   localparam int CFG2_STF_BIT   = 3;
   localparam int CFG2_ENDRV_BIT = 2;
   localparam int CFG2_NRST_BIT  = 1;
   localparam int CFG2_NSAFE_BIT = 0;

   // Writable bit masks and reset values
   localparam logic [7:0] CFG1_WMASK = 8'h3f;
   localparam logic [7:0] CFG2_WMASK = 8'hbf;
   localparam logic [7:0] CFG1_RST   = 8'h00;
   localparam logic [7:0] CFG2_RST   = 8'h00;

   // Timeout select codes
   localparam logic [1:0] TO_SEL_640 = 2'h0;
   localparam logic [1:0] TO_SEL_320 = 2'h1;
   localparam logic [1:0] TO_SEL_5   = 2'h2;
   localparam logic [1:0] TO_SEL_1P25 = 2'h3;

   // Timing: clock rate, timer tick and the four periods
   localparam int CLK_KHZ        = 25000;
   localparam int TICK_US        = 250;
   localparam int TICK_CYC       = TICK_US * CLK_KHZ / 1000;
   localparam int SAFE_STATE_TIMEOUT_SEL_640_US = 640000;
   localparam int SAFE_STATE_TIMEOUT_SEL_320_US = 320000;
   localparam int SAFE_STATE_TIMEOUT_SEL_5_US   = 5000;
   localparam int SAFE_STATE_TIMEOUT_SEL_1P25_US = 1250;
   localparam int TK_W           = 12;
   localparam logic [TK_W-1:0] TK_640  = TK_W'(SAFE_STATE_TIMEOUT_SEL_640_US / TICK_US);
   localparam logic [TK_W-1:0] TK_320  = TK_W'(SAFE_STATE_TIMEOUT_SEL_320_US / TICK_US);
   localparam logic [TK_W-1:0] TK_5    = TK_W'(SAFE_STATE_TIMEOUT_SEL_5_US / TICK_US);
   localparam logic [TK_W-1:0] TK_1P25 = TK_W'(SAFE_STATE_TIMEOUT_SEL_1P25_US / TICK_US);

endpackage

// [rtl/scr_safe_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_safe_timer
   import scr_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC
)
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // Control
   input  wire logic       start,
   input  wire logic       stop,
   input  wire logic [1:0] sel,
   // Result
   output var  logic       expired
);

   localparam int PW = $clog2(TICK_CYC_P + 1);

   typedef enum logic {T_IDLE, T_RUN} scr_tmr_state_t;

   scr_tmr_state_t        state_r;
   logic [PW-1:0]         pre_r;
   logic [TK_W-1:0]       cnt_r;
   logic [TK_W-1:0]       load_nxt;
   logic                  tick;

   generate
      if (TICK_CYC_P < 2)
      begin : g_chk
         $error("scr_safe_timer: tick divider must be at least 2 cycles");
      end
   endgenerate

   // Period decode from the select code
   always_comb
   begin
      case (sel)
         TO_SEL_640:  load_nxt = TK_640;
         TO_SEL_320:  load_nxt = TK_320;
         TO_SEL_5:    load_nxt = TK_5;
         default:     load_nxt = TK_1P25;
      endcase
   end

   assign tick = (pre_r == PW'(TICK_CYC_P - 1));

   // Countdown; a start restarts even a running count
   always_ff @(posedge mclk)
   begin
      if (srst || stop)
      begin
         state_r <= T_IDLE;
         pre_r   <= '0;
         cnt_r   <= '0;
      end
      else if (start)
      begin
         state_r <= T_RUN;
         pre_r   <= '0;
         cnt_r   <= load_nxt;
      end
      else
      begin
         case (state_r)
            T_RUN:
            begin
               pre_r <= tick ? '0 : pre_r + PW'(1);
               if (tick)
               begin
                  cnt_r <= cnt_r - TK_W'(1);
                  if (cnt_r == TK_W'(1))
                     state_r <= T_IDLE;
               end
            end
            default: state_r <= T_IDLE;
         endcase
      end
   end

   // One-cycle expiry pulse
   always_ff @(posedge mclk)
   begin
      if (srst || stop || start)
         expired <= 1'b0;
      else
         expired <= (state_r == T_RUN) && tick && (cnt_r == TK_W'(1));
   end

   a_timer_load : assert property (@(posedge mclk) disable iff (srst)
      start && !stop |=> state_r == T_RUN && cnt_r == $past(load_nxt))
      else $error("SAFE timer not loaded with selected period");

endmodule
`default_nettype wire

// [rtl/scr_safety_cfg.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_safety_cfg
   import scr_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC,
   parameter int GROUPS     = 4
)
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              srst,
   // Register command port from the serial link decoder
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire logic              cmd_sel,
   input  wire logic [7:0]        cmd_wdata,
   // Register answer
   output var  logic              rsp_valid,
   output var  logic [7:0]        rsp_rdata,
   output var  logic              rsp_refused,
   // Device context
   input  wire logic [2:0]        dev_state,
   input  wire logic              cfg_lock,
   input  wire logic              timeout_exit_disable,
   input  wire logic [3:0]        device_error_counter,
   input  wire logic [GROUPS-1:0] selftest_group_start,
   // Fault events
   input  wire logic              clock_warning,
   input  wire logic              selftest_fail,
   input  wire logic              enable_driver_error,
   input  wire logic              reset_out_error,
   // State change requests and controls
   output var  logic              safe_exit_reset,
   output var  logic              safe_locked,
   output var  logic              go_safe_req,
   output var  logic              go_reset_req,
   output var  logic              scheduler_run,
   output var  logic              auto_selftest_run,
   // Register contents for the rest of the device
   output var  logic [7:0]        safety_config_one,
   output var  logic [7:0]        safety_config_two
);

   logic [2:0] prev_state_r;
   logic       wr_ok;
   logic       in_diag_act;
   logic       safe_entry;
   logic       reset_entry;
   logic       tmr_expired;
   logic       exit_allowed;
   logic       safe_cause;
   logic       reset_cause;

   generate
      if (GROUPS < 1 || GROUPS > 8)
      begin : g_chk
         $error("scr_safety_cfg: GROUPS must be 1 to 8");
      end
   endgenerate

   // Write permission and state decode
   assign wr_ok       = (dev_state == DST_DIAG) && !cfg_lock;
   assign in_diag_act = (dev_state == DST_DIAG) || (dev_state == DST_ACTIVE);
   assign safe_entry  = (dev_state == DST_SAFE) && (prev_state_r != DST_SAFE);
   assign reset_entry = (dev_state == DST_RESET) && (prev_state_r == DST_DIAG
                        || prev_state_r == DST_ACTIVE || prev_state_r == DST_SAFE);

   // Previous state, for entry detection
   always_ff @(posedge mclk)
   begin
      if (srst)
         prev_state_r <= DST_OFF;
      else
         prev_state_r <= dev_state;
   end

   // Config registers; reserved bits never store a one
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         safety_config_one <= CFG1_RST;
         safety_config_two <= CFG2_RST;
      end
      else if (cmd_valid && cmd_write && wr_ok)
      begin
         if (cmd_sel == CMD_SEL_ONE)
            safety_config_one <= cmd_wdata & CFG1_WMASK;
         else
            safety_config_two <= cmd_wdata & CFG2_WMASK;
      end
   end

   // Answer one cycle after every command; a blocked write is flagged, not stored
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rsp_valid   <= 1'b0;
         rsp_rdata   <= 8'h00;
         rsp_refused <= 1'b0;
      end
      else
      begin
         rsp_valid   <= cmd_valid;
         rsp_refused <= cmd_valid && cmd_write && !wr_ok;
         if (cmd_valid && !cmd_write)
            rsp_rdata <= (cmd_sel == CMD_SEL_ONE) ? safety_config_one : safety_config_two;
      end
   end

   // SAFE timer; stopped as soon as the device leaves SAFE
   scr_safe_timer #(
      .TICK_CYC_P (TICK_CYC_P)
   ) u_timer (
      .mclk    (mclk),
      .srst    (srst),
      .start   (safe_entry),
      .stop    (dev_state != DST_SAFE),
      .sel     (safety_config_one[CFG1_TO_MSB:CFG1_TO_LSB]),
      .expired (tmr_expired)
   );

   // Exit allowed unless disabled and the error count is past the threshold
   assign exit_allowed = !timeout_exit_disable
                      || (device_error_counter
                          <= safety_config_one[CFG1_TH_MSB:CFG1_TH_LSB]);

   // SAFE exit decision; the lock holds until the device leaves SAFE
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         safe_exit_reset <= 1'b0;
         safe_locked     <= 1'b0;
      end
      else
      begin
         safe_exit_reset <= tmr_expired && (dev_state == DST_SAFE) && exit_allowed;
         if (dev_state != DST_SAFE)
            safe_locked <= 1'b0;
         else if (tmr_expired && !exit_allowed)
            safe_locked <= 1'b1;
      end
   end

   // Fault responses; reset-output error picks RESET over SAFE
   assign reset_cause = reset_out_error && safety_config_two[CFG2_NRST_BIT]
                        && (in_diag_act || dev_state == DST_SAFE);
   assign safe_cause  = in_diag_act && (
                           (clock_warning && safety_config_two[CFG2_CLKW_BIT])
                        || (selftest_fail && safety_config_two[CFG2_STF_BIT])
                        || (enable_driver_error && safety_config_two[CFG2_ENDRV_BIT])
                        || (reset_out_error && safety_config_two[CFG2_NSAFE_BIT]
                            && !safety_config_two[CFG2_NRST_BIT]));

   // Requests stand for one cycle per event cycle; the state machine acts on them
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         go_safe_req  <= 1'b0;
         go_reset_req <= 1'b0;
      end
      else
      begin
         go_safe_req  <= safe_cause;
         go_reset_req <= reset_cause;
      end
   end

   // Scheduler gate and automatic self-test launch on RESET entry
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         scheduler_run     <= 1'b0;
         auto_selftest_run <= 1'b0;
      end
      else
      begin
         scheduler_run <= (dev_state == DST_ACTIVE)
                          && safety_config_two[CFG2_SCHED_BIT]
                          && (|selftest_group_start);
         auto_selftest_run <= reset_entry && !safety_config_two[CFG2_AUTO_BIT];
      end
   end

   // Checks on the outputs
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_bad_write;
      cmd_valid && cmd_write && !wr_ok;
   endsequence

   sequence s_good_write_one;
      cmd_valid && cmd_write && wr_ok && cmd_sel == CMD_SEL_ONE;
   endsequence

   sequence s_safe_expiry;
      tmr_expired && dev_state == DST_SAFE;
   endsequence

   a_write_guard : assert property (s_bad_write |=>
      rsp_refused && $stable(safety_config_one) && $stable(safety_config_two))
      else $error("Write outside DIAGNOSTIC or while locked was taken");

   a_write_take : assert property (s_good_write_one |=>
      !rsp_refused && safety_config_one == ($past(cmd_wdata) & CFG1_WMASK))
      else $error("Permitted write to first register not stored");

   a_reserved_zero : assert property (safety_config_one[7:6] == 2'h0
      && safety_config_two[6] == 1'b0)
      else $error("Reserved bit holds a one");

   a_exit_free : assert property (s_safe_expiry ##0 (!timeout_exit_disable
      || device_error_counter <= safety_config_one[3:0]) |=> safe_exit_reset && !safe_locked)
      else $error("Timer expiry did not lead to RESET");

   a_lock_hold : assert property (s_safe_expiry ##0 (timeout_exit_disable
      && device_error_counter > safety_config_one[3:0]) |=> safe_locked && !safe_exit_reset)
      else $error("Device left SAFE despite error lock");

   a_clock_warn : assert property (in_diag_act && clock_warning
      && safety_config_two[7] |=> go_safe_req)
      else $error("Clock warning did not request SAFE");

   a_sched_gate : assert property (##1 scheduler_run == $past(dev_state == DST_ACTIVE
      && safety_config_two[5] && (|selftest_group_start)))
      else $error("Scheduler gate wrong");

   a_reset_prio : assert property (reset_out_error && safety_config_two[1]
      && in_diag_act && !clock_warning && !selftest_fail && !enable_driver_error
      |=> go_reset_req && !go_safe_req)
      else $error("Reset-output error did not prefer RESET");

   a_auto_test : assert property (reset_entry |=>
      auto_selftest_run == !$past(safety_config_two[4]))
      else $error("Automatic self-test launch wrong");

endmodule
`default_nettype wire

// [sim/scr_mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_mcu_model
   import scr_pkg::*;
(
   // Clock
   input  wire logic       mclk,
   // Command side
   output var  logic       cmd_valid,
   output var  logic       cmd_write,
   output var  logic       cmd_sel,
   output var  logic [7:0] cmd_wdata,
   // Answer side
   input  wire logic       rsp_valid,
   input  wire logic [7:0] rsp_rdata,
   input  wire logic       rsp_refused
);
   // Idle command lines
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_sel   = 1'b0;
      cmd_wdata = 8'h00;
   end

   // One command; lines move only at the falling edge, answer taken a cycle later
   task automatic access(input logic wr, input logic sel, input logic [7:0] wd,
                         output logic ok, output logic [7:0] rd, output logic refused);
      @(negedge mclk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_sel   <= sel;
      cmd_wdata <= wd;
      @(posedge mclk);
      @(negedge mclk);
      ok      = rsp_valid;
      rd      = rsp_rdata;
      refused = rsp_refused;
      // Scramble released data so a stale byte never looks live
      cmd_valid <= 1'b0;
      cmd_wdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// [sim/test_safety_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_safety_config_regs
   import scr_pkg::*;
();
   localparam int TK = 4;
   logic       mclk, srst, cmd_valid, cmd_write, cmd_sel, rsp_valid, rsp_refused;
   logic [7:0] cmd_wdata, rsp_rdata, safety_config_one, safety_config_two;
   logic [2:0] dev_state;
   logic       cfg_lock, timeout_exit_disable, clock_warning, selftest_fail;
   logic       enable_driver_error, reset_out_error, safe_exit_reset, safe_locked;
   logic       go_safe_req, go_reset_req, scheduler_run, auto_selftest_run;
   logic [3:0] device_error_counter, selftest_group_start;
   int         mismatches, samples_checked;
   int         ticks [4] = '{2560, 1280, 20, 5};

   scr_safety_cfg #(.TICK_CYC_P(TK), .GROUPS(4)) scr_safety_cfg_i (.mclk, .srst,
      .cmd_valid, .cmd_write, .cmd_sel, .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_refused,
      .dev_state, .cfg_lock, .timeout_exit_disable, .device_error_counter,
      .selftest_group_start, .clock_warning, .selftest_fail, .enable_driver_error,
      .reset_out_error, .safe_exit_reset, .safe_locked, .go_safe_req, .go_reset_req,
      .scheduler_run, .auto_selftest_run, .safety_config_one, .safety_config_two);

   scr_mcu_model scr_mcu_model_i (.mclk, .cmd_valid, .cmd_write, .cmd_sel, .cmd_wdata,
      .rsp_valid, .rsp_rdata, .rsp_refused);

   // Free-running clock, 40 ns period
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc();
      @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic wr(input logic sel, input logic [7:0] d, input logic exp_ref);
      logic       ok, rf;
      logic [7:0] rd;
      scr_mcu_model_i.access(1'b1, sel, d, ok, rd, rf);
      chk("write answer", 8'h01, {7'h0, ok});
      chk("write refused", {7'h0, exp_ref}, {7'h0, rf});
   endtask

   task automatic rd_chk(input logic sel, input logic [7:0] exp);
      logic       ok, rf;
      logic [7:0] rd;
      scr_mcu_model_i.access(1'b0, sel, 8'h00, ok, rd, rf);
      chk("read answer", 8'h01, {7'h0, ok});
      chk("read data", exp, rd);
   endtask

   // Store masks, lock and state gating of writes
   task automatic t_access();
      rd_chk(1'b0, 8'h00);
      rd_chk(1'b1, 8'h00);
      dev_state = DST_DIAG;
      wr(1'b0, 8'hff, 1'b0);
      rd_chk(1'b0, 8'h3f);
      wr(1'b1, 8'hff, 1'b0);
      rd_chk(1'b1, 8'hbf);
      cfg_lock = 1'b1;
      wr(1'b0, 8'h00, 1'b1);
      rd_chk(1'b0, 8'h3f);
      cfg_lock = 1'b0;
      dev_state = DST_ACTIVE;
      wr(1'b1, 8'h00, 1'b1);
      rd_chk(1'b1, 8'hbf);
   endtask

   // Each fault cause with its enable bit set and clear
   task automatic t_faults();
      logic [7:0] bits [4] = '{8'h80, 8'h08, 8'h04, 8'h01};
      for (int i = 0; i < 4; i++)
         for (int en = 0; en < 2; en++)
         begin
            dev_state = DST_DIAG;
            wr(1'b1, (en != 0) ? bits[i] : 8'h00, 1'b0);
            dev_state = DST_ACTIVE;
            {clock_warning, selftest_fail, enable_driver_error, reset_out_error} = 4'h8 >> i;
            cyc();
            chk("safe request", 8'(en), {7'h0, go_safe_req});
            {clock_warning, selftest_fail, enable_driver_error, reset_out_error} = 4'h0;
         end
      dev_state = DST_DIAG;
      wr(1'b1, 8'h83, 1'b0);
      dev_state = DST_ACTIVE;
      reset_out_error = 1'b1;
      cyc();
      chk("reset request", 8'h01, {7'h0, go_reset_req});
      chk("safe request", 8'h00, {7'h0, go_safe_req});
      // From SAFE the reset-output error may still ask for RESET, never for SAFE
      dev_state = DST_SAFE;
      cyc();
      chk("reset request in safe", 8'h01, {7'h0, go_reset_req});
      chk("safe request in safe", 8'h00, {7'h0, go_safe_req});
      reset_out_error = 1'b0;
      dev_state = DST_OFF;
      clock_warning = 1'b1;
      cyc();
      chk("safe request", 8'h00, {7'h0, go_safe_req});
      clock_warning = 1'b0;
   endtask

   // Scheduler needs ACTIVE, its enable and a group start
   task automatic t_sched();
      dev_state = DST_DIAG;
      wr(1'b1, 8'h20, 1'b0);
      dev_state = DST_ACTIVE;
      selftest_group_start = 4'h2;
      repeat (2) cyc();
      chk("scheduler", 8'h01, {7'h0, scheduler_run});
      selftest_group_start = 4'h0;
      repeat (2) cyc();
      chk("scheduler", 8'h00, {7'h0, scheduler_run});
   endtask

   // Automatic self-test on RESET entry, skipped when disabled
   task automatic t_auto();
      for (int dis = 0; dis < 2; dis++)
      begin
         dev_state = DST_DIAG;
         wr(1'b1, (dis != 0) ? 8'h10 : 8'h00, 1'b0);
         dev_state = DST_RESET;
         cyc();
         chk("auto self-test", 8'(dis == 0), {7'h0, auto_selftest_run});
         cyc();
         chk("auto self-test end", 8'h00, {7'h0, auto_selftest_run});
      end
   endtask

   // SAFE timer with threshold 5; checks the cycle before and at expiry
   task automatic t_safe(input logic [1:0] sel, input logic dis, input logic [3:0] cnt,
                         input logic lock);
      int n;
      n = ticks[sel] * TK;
      dev_state = DST_DIAG;
      wr(1'b0, {2'h0, sel, 4'h5}, 1'b0);
      timeout_exit_disable = dis;
      device_error_counter = cnt;
      dev_state = DST_SAFE;
      @(posedge mclk);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
      chk("early expiry", 8'h00, {6'h0, safe_exit_reset, safe_locked});
      cyc();
      chk("timer exit", 8'(!lock), {7'h0, safe_exit_reset});
      chk("lock held", 8'(lock), {7'h0, safe_locked});
      dev_state = DST_RESET;
      repeat (2) cyc();
      chk("lock cleared", 8'h00, {7'h0, safe_locked});
   endtask

   // Mid-run reset while both registers hold ones; the start-up check alone sees only zeros
   task automatic t_reset();
      srst = 1'b1;
      repeat (2) cyc();
      srst = 1'b0;
      chk("config one mid reset", 8'h00, safety_config_one);
      chk("config two mid reset", 8'h00, safety_config_two);
      chk("lock after reset", 8'h00, {7'h0, safe_locked});
      rd_chk(1'b0, 8'h00);
      rd_chk(1'b1, 8'h00);
   endtask

   // Main sequence
   initial
   begin
      srst = 1'b1;
      dev_state = DST_OFF;
      {cfg_lock, timeout_exit_disable, clock_warning, selftest_fail} = 4'h0;
      {enable_driver_error, reset_out_error} = 2'h0;
      device_error_counter = 4'h0;
      selftest_group_start = 4'h0;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      srst = 1'b0;
      chk("config one reset", 8'h00, safety_config_one);
      chk("config two reset", 8'h00, safety_config_two);
      t_access();
      t_faults();
      t_sched();
      t_auto();
      t_safe(2'h3, 1'b0, 4'hf, 1'b0);
      t_safe(2'h3, 1'b1, 4'h5, 1'b0);
      t_safe(2'h3, 1'b1, 4'h6, 1'b1);
      t_safe(2'h2, 1'b0, 4'h0, 1'b0);
      t_safe(2'h1, 1'b0, 4'h0, 1'b0);
      t_safe(2'h0, 1'b0, 4'h0, 1'b0);
      t_reset();
      print_verdict();
   end

   // Watchdog: the run needs well under 1 ms
   initial
   begin
      #2000000;
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
